// *** kbi_cfg.svh ***
// Purpose: Constants of the keyboard level interrupt block.
// Assumes: Special function register offsets on an 8-bit address bus.
// Notes: Definitions only.
`ifndef KBI_CFG_SVH
`define KBI_CFG_SVH
`define KBI_ADDR_W 8
`define KBI_DATA_W 8
`define KBI_OFS_LEVEL_SELECT 8'h9C
`define KBI_OFS_LINE_ENABLE 8'h9D
`define KBI_OFS_LINE_FLAGS 8'h9E
`define KBI_RST_LEVEL_SELECT 8'h00
`define KBI_RST_LINE_ENABLE 8'h00
`define KBI_RST_LINE_FLAGS 8'h00
`define KBI_SYNC_STAGES 2
`define KBI_RST_PIN_LEVEL 1'b1
`define KBI_RST_READ_DATA 8'h00
`endif

// *** kbi_keys.sv ***
// Purpose: Key matrix model on the port one pins.
// Assumes: Pins are pulled up; a pressed key pulls its line low.
// Notes: Released lines read high, so high-level detection sees them.
`timescale 1ns/100ps
module kbi_keys (
	// Keys
	input wire logic [7:0] press_i,
	// Pins
	output logic [7:0] pins_o
);
	assign pins_o = ~press_i;
endmodule // kbi_keys

// *** kbi_pkg.sv ***
// Purpose: Types of the keyboard level interrupt block.
// Assumes: Eight keyboard lines.
// Notes: Offsets and reset values live in kbi_cfg.svh.
package kbi_pkg;
	typedef logic [7:0] kbi_byte_type;
endpackage

// *** kbi_sync.sv ***
// Purpose: Two-stage synchroniser for one port line.
// Assumes: Pin changes are slow compared with the core clock.
// Notes: Only the second stage is visible outside.
`timescale 1ns/100ps
`include "kbi_cfg.svh"
module kbi_sync (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_b_i,
	// Line
	input wire logic pin_i,
	output logic sync_o
);
	logic stage_one;
	logic stage_two;
	logic next_stage_one;
	logic next_stage_two;

	always_comb begin
		next_stage_one = pin_i;
		next_stage_two = stage_one;
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			// Reset to the pulled-up idle level, so a low-level select
			// does not see a false key press just after reset.
			stage_one <= `KBI_RST_PIN_LEVEL;
			stage_two <= `KBI_RST_PIN_LEVEL;
		end else begin
			stage_one <= next_stage_one;
			stage_two <= next_stage_two;
		end
	end

	assign sync_o = stage_two;
endmodule // kbi_sync

// *** kbi_top.sv ***
// Purpose: Eight-line keyboard level interrupt with three registers.
// Assumes: Core register port with one-cycle read and write strobes.
// Notes on behaviour
// - Each line sets its own flag while its pin shows the chosen level.
// - A flag requests the shared interrupt only if its line is enabled.
// - Flag register is read-only; a read of it clears every flag whose line is not at its chosen level.
// - A disabled line stays a plain port pin and adds no request.
// - An enabled line lets its flag drive the shared request.
// - Level select zero makes a low pin the detection condition.
// - Level select one makes a high pin the detection condition.
// - Reset clears flags, enables and level selects to zero.
// - All lines share one vector, gated by one global enable.
// - Detection keeps working in idle and power-down to wake the core.
// Notes: The global enable is a core-side input, not a register here.
`timescale 1ns/100ps
`include "kbi_cfg.svh"
module kbi_top #(
	// Number of keyboard lines served
	parameter int LINE_COUNT = `KBI_DATA_W
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_b_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// Port one pins and core controls
	input wire logic [7:0] port_one_pins_i,
	input wire logic keypad_global_irq_enable_i,
	// Results
	output logic [7:0] key_line_enable_alias_o,
	output logic key_irq_o,
	output logic key_wake_o
);
	kbi_pkg::kbi_byte_type key_level_select;
	kbi_pkg::kbi_byte_type key_line_enable;
	kbi_pkg::kbi_byte_type key_line_flags;
	kbi_pkg::kbi_byte_type next_key_level_select;
	kbi_pkg::kbi_byte_type next_key_line_enable;
	kbi_pkg::kbi_byte_type next_key_line_flags;
	kbi_pkg::kbi_byte_type next_rdata;
	kbi_pkg::kbi_byte_type pins_sync;
	kbi_pkg::kbi_byte_type detect;
	logic next_irq;
	logic next_wake;
	logic flags_read;
	kbi_pkg::kbi_byte_type enabled_flags;

	// The registers are bytes, so the line count is fixed by their width.
	if (LINE_COUNT != `KBI_DATA_W) begin : g_bad_line_count
		$error("line count must equal the register width");
	end
	// The synchroniser module is built with exactly two stages.
	if (`KBI_SYNC_STAGES != 2) begin : g_bad_sync_depth
		$error("synchroniser depth must be two");
	end

	genvar gi;
	generate
		for (gi = 0; gi < LINE_COUNT; gi++) begin : g_line
			kbi_sync u_sync (
				.clock_i(clock_i),
				.rst_b_i(rst_b_i),
				.pin_i(port_one_pins_i[gi]),
				.sync_o(pins_sync[gi])
			);
		end
	endgenerate

	// Matching level: a one bit selects high, a zero bit selects low.
	assign detect = ~(pins_sync ^ key_level_select);
	assign flags_read = reg_rd_i && (reg_addr_i == `KBI_OFS_LINE_FLAGS);

	// Control registers: level select and line enable.
	always_comb begin
		next_key_level_select = key_level_select;
		next_key_line_enable = key_line_enable;
		if (reg_wr_i && reg_addr_i == `KBI_OFS_LEVEL_SELECT) begin
			next_key_level_select = reg_wdata_i;
		end
		if (reg_wr_i && reg_addr_i == `KBI_OFS_LINE_ENABLE) begin
			next_key_line_enable = reg_wdata_i;
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			key_level_select <= `KBI_RST_LEVEL_SELECT;
			key_line_enable <= `KBI_RST_LINE_ENABLE;
		end else begin
			key_level_select <= next_key_level_select;
			key_line_enable <= next_key_line_enable;
		end
	end

	// Flags have no write path at all, so software can only clear them.
	always_comb begin
		next_key_line_flags = key_line_flags;
		if (flags_read) begin
			next_key_line_flags = 8'h00;
		end
		// Set wins over the read clear so a press is never lost.
		next_key_line_flags = next_key_line_flags | detect;
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			key_line_flags <= `KBI_RST_LINE_FLAGS;
		end else begin
			key_line_flags <= next_key_line_flags;
		end
	end

	// Read data stands for one cycle and is zero between reads.
	always_comb begin
		next_rdata = 8'h00;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				`KBI_OFS_LEVEL_SELECT: next_rdata = key_level_select;
				`KBI_OFS_LINE_ENABLE: next_rdata = key_line_enable;
				`KBI_OFS_LINE_FLAGS: next_rdata = key_line_flags;
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= `KBI_RST_READ_DATA;
		end else begin
			reg_rdata_o <= next_rdata;
		end
	end

	// Requests. Disabled lines contribute nothing; enabled ones share one.
	always_comb begin
		enabled_flags = key_line_flags & key_line_enable;
		next_irq = keypad_global_irq_enable_i && (|enabled_flags);
		// Wake ignores the global enable so a masked key still wakes the core.
		next_wake = |enabled_flags;
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			key_line_enable_alias_o <= `KBI_RST_LINE_ENABLE;
			key_irq_o <= 1'b0;
			key_wake_o <= 1'b0;
		end else begin
			key_line_enable_alias_o <= next_key_line_enable;
			key_irq_o <= next_irq;
			key_wake_o <= next_wake;
		end
	end

	// Register side checks.
	flags_write_ignored_a: assert property (
		@(posedge clock_i) disable iff (!rst_b_i)
		(reg_wr_i && reg_addr_i == `KBI_OFS_LINE_FLAGS && !reg_rd_i)
		|=> ((key_line_flags & ~$past(key_line_flags))
		== ($past(detect) & ~$past(key_line_flags))))
		else $error("flag register changed by a write");
	read_clears_flags_a: assert property (
		@(posedge clock_i) disable iff (!rst_b_i)
		flags_read |=> (key_line_flags == $past(detect)))
		else $error("flag read did not clear flags");
	flags_readback_a: assert property (
		@(posedge clock_i) disable iff (!rst_b_i)
		flags_read |=> (reg_rdata_o == $past(key_line_flags)))
		else $error("flag read returned a wrong value");
	flags_sticky_a: assert property (
		@(posedge clock_i) disable iff (!rst_b_i)
		!flags_read |=> ((key_line_flags & $past(key_line_flags))
		== $past(key_line_flags)))
		else $error("flag cleared without a read");
	select_write_a: assert property (
		@(posedge clock_i) disable iff (!rst_b_i)
		(reg_wr_i && reg_addr_i == `KBI_OFS_LEVEL_SELECT)
		|=> (key_level_select == $past(reg_wdata_i)))
		else $error("level select write lost");
	enable_write_a: assert property (
		@(posedge clock_i) disable iff (!rst_b_i)
		(reg_wr_i && reg_addr_i == `KBI_OFS_LINE_ENABLE)
		|=> (key_line_enable == $past(reg_wdata_i)))
		else $error("line enable write lost");

	// Detection checks, on all lines at once.
	detect_sets_flag_a: assert property (
		@(posedge clock_i) disable iff (!rst_b_i)
		1'b1 |=> ((key_line_flags & $past(detect)) == $past(detect)))
		else $error("detected level did not set its flag");
	no_spurious_set_a: assert property (
		@(posedge clock_i) disable iff (!rst_b_i)
		1'b1 |=> ((key_line_flags & ~$past(key_line_flags)
		& ~$past(detect)) == 8'h00))
		else $error("flag set without a detected level");
	low_level_a: assert property (
		@(posedge clock_i) disable iff (!rst_b_i)
		1'b1 |=> ((key_line_flags & $past(~key_level_select & ~pins_sync))
		== $past(~key_level_select & ~pins_sync)))
		else $error("low level not detected");
	high_level_a: assert property (
		@(posedge clock_i) disable iff (!rst_b_i)
		1'b1 |=> ((key_line_flags & $past(key_level_select & pins_sync))
		== $past(key_level_select & pins_sync)))
		else $error("high level not detected");
	sync_delay_a: assert property (
		@(posedge clock_i) disable iff (!rst_b_i)
		1'b1 |=> ##1 (pins_sync == $past(port_one_pins_i, 2)))
		else $error("pin synchroniser delay wrong");

	// Request checks.
	irq_gated_a: assert property (
		@(posedge clock_i) disable iff (!rst_b_i)
		key_irq_o == $past(keypad_global_irq_enable_i
		&& |(key_line_flags & key_line_enable)))
		else $error("interrupt request mismatch");
	disabled_silent_a: assert property (
		@(posedge clock_i) disable iff (!rst_b_i)
		(key_line_enable == 8'h00) |=> !key_irq_o)
		else $error("request from disabled lines");
	disabled_no_wake_a: assert property (
		@(posedge clock_i) disable iff (!rst_b_i)
		(key_line_enable == 8'h00) |=> !key_wake_o)
		else $error("wake from disabled lines");
	enabled_drives_a: assert property (
		@(posedge clock_i) disable iff (!rst_b_i)
		(keypad_global_irq_enable_i && |(key_line_flags & key_line_enable))
		|=> key_irq_o)
		else $error("enabled flag gave no request");
	global_gate_a: assert property (
		@(posedge clock_i) disable iff (!rst_b_i)
		!keypad_global_irq_enable_i |=> !key_irq_o)
		else $error("request while globally disabled");
	wake_ungated_a: assert property (
		@(posedge clock_i) disable iff (!rst_b_i)
		(!keypad_global_irq_enable_i
		&& |(key_line_flags & key_line_enable)) |=> key_wake_o)
		else $error("masked key gave no wake");
	wake_follows_a: assert property (
		@(posedge clock_i) disable iff (!rst_b_i)
		key_wake_o == $past(|(key_line_flags & key_line_enable)))
		else $error("wake request mismatch");
endmodule // kbi_top

// *** tb.sv ***
// Purpose: Self-checking bench of the keyboard level interrupt.
// Assumes: Registers are reached with one-cycle read and write strobes.
// Notes: An idle cycle separates accesses so no strobe is set twice.
`timescale 1ns/100ps
`include "kbi_cfg.svh"
module tb;
	logic clock_i = 0, rst_b_i = 0, wr = 0, rd = 0, gen = 0, irq, wake;
	logic [7:0] addr = 8'h00, wdata = 8'h00, press = 8'h00;
	logic [7:0] pins, rdata, alias_en;
	int error_cnt = 0, comparisons = 0, cyc = 0;
	localparam logic [7:0] LS = `KBI_OFS_LEVEL_SELECT;
	localparam logic [7:0] EN = `KBI_OFS_LINE_ENABLE;
	localparam logic [7:0] FL = `KBI_OFS_LINE_FLAGS;
	kbi_keys kbi_keys_i (.press_i(press), .pins_o(pins));
	kbi_top kbi_top_i (.clock_i(clock_i), .rst_b_i(rst_b_i),
		.reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.port_one_pins_i(pins), .keypad_global_irq_enable_i(gen),
		.key_line_enable_alias_o(alias_en), .key_irq_o(irq),
		.key_wake_o(wake));
	initial forever #4 clock_i = ~clock_i;
	task finish_test;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// The whole sequence needs well under 200 cycles.
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			error_cnt++;
			finish_test();
		end
	end
	task check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task acc(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic [7:0] exp);
		addr = a;
		wdata = d;
		wr = w;
		rd = !w;
		@(negedge clock_i);
		if (!w)
			check(rdata, exp);
		wr = 0;
		rd = 0;
		@(negedge clock_i);
	endtask
	initial begin
		repeat (16) @(negedge clock_i);
		rst_b_i = 1;
		@(negedge clock_i);
		acc(0, LS, 8'h00, 8'h00);
		acc(0, EN, 8'h00, 8'h00);
		acc(0, FL, 8'h00, 8'h00);
		press = 8'h08;
		repeat (6) @(negedge clock_i);
		check({6'h00, irq, wake}, 8'h00);
		acc(0, FL, 8'h00, 8'h08);
		acc(0, FL, 8'h00, 8'h08);
		press = 8'h00;
		repeat (6) @(negedge clock_i);
		acc(0, FL, 8'h00, 8'h08);
		acc(0, FL, 8'h00, 8'h00);
		acc(1, FL, 8'hFF, 8'h00);
		acc(0, FL, 8'h00, 8'h00);
		acc(0, 8'h9F, 8'h00, 8'h00);
		acc(1, EN, 8'h80, 8'h00);
		acc(1, LS, 8'h80, 8'h00);
		gen = 1;
		repeat (6) @(negedge clock_i);
		check(alias_en, 8'h80);
		check({6'h00, irq, wake}, 8'h03);
		gen = 0;
		repeat (3) @(negedge clock_i);
		check({6'h00, irq, wake}, 8'h01);
		acc(0, EN, 8'h00, 8'h80);
		acc(0, FL, 8'h00, 8'h80);
		acc(1, LS, 8'h00, 8'h00);
		acc(0, FL, 8'h00, 8'h80);
		repeat (3) @(negedge clock_i);
		acc(0, FL, 8'h00, 8'h00);
		check({6'h00, irq, wake}, 8'h00);
		// A reset in mid-run must clear registers that hold nonzero values.
		acc(1, LS, 8'hFF, 8'h00);
		acc(1, EN, 8'hFF, 8'h00);
		rst_b_i = 0;
		repeat (2) @(negedge clock_i);
		rst_b_i = 1;
		@(negedge clock_i);
		check(alias_en, 8'h00);
		check({6'h00, irq, wake}, 8'h00);
		acc(0, LS, 8'h00, 8'h00);
		acc(0, EN, 8'h00, 8'h00);
		acc(0, FL, 8'h00, 8'h00);
		finish_test();
	end
endmodule // tb
